// [src/telemetry_readback_registers.v]
// Purpose: Read-only telemetry bank behind a serial two-wire target port
// Assumes: Field inputs come from logic on mclk; scl and sda come from pins
// Notes: Bus clock must be well below mclk/8 for the three-stage pin sampling
//
// Overview of operation
// [R1] Word 0x02 returns voltage set-point at 12:8, 6:0 with parity at 15, 7.
// [R2] Word 0x04 returns current set-point at 8, 6:0 with parity at 15, 7.
// [R3] Word 0x06 returns overvoltage threshold at 12:8, 6:0 with parity bits.
// [R4] Word 0x08 returns undervoltage threshold at 12:8, 6:0 with parity bits.
// [R5] Word 0x0A holds current set-point high byte, power limit low byte, no parity.
// [R6] Word 0x0C upper byte holds overvoltage, undervoltage, short and sense reactions.
// [R7] Word 0x0C lower byte holds timeouts, voltage-only reaction and timer.
// [R8] Word 0x0E reports configuration flags at 14:9 and cable compensation at 3:0.
// [R9] Word 0x10 returns measured current at 8, 6:0 with parity at 15, 7.
// [R10] Word 0x12 returns 12-bit measured voltage; bits 15:12 read zero.
// [R11] Measured voltage step is 20, 50 or 100 mV by output range.
// [R12] Every parity bit makes its byte carry odd parity.
// [R13] Host writes sub-address to location 0x80, then reads word from 0x80.
// [R14] Unassigned bits read zero; writes never change read-only words.
`timescale 1ns/10ps
`include "telemetry_readback_regs.vh"

module telemetry_readback_registers #(
  parameter [6:0] TARGET_ADDR = 7'h18
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Two-wire target pins
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // Programmed set-points and thresholds
  input wire [11:0] voltage_setpoint_field,
  input wire [7:0] current_setpoint_field,
  input wire [11:0] overvoltage_threshold_field,
  input wire [11:0] undervoltage_threshold_field,
  input wire [7:0] power_limit_field,
  // Fault-response and timer selections
  input wire [1:0] overvoltage_reaction,
  input wire [1:0] undervoltage_reaction,
  input wire [1:0] output_short_reaction,
  input wire [1:0] sense_pin_short_reaction,
  input wire [1:0] undervoltage_timeout_sel,
  input wire [1:0] watchdog_timeout_sel,
  input wire [1:0] voltage_only_reaction,
  input wire [1:0] voltage_only_timer,
  // Configuration flags
  input wire bus_switch_enable,
  input wire bleeder_enable,
  input wire supply_turn_off,
  input wire fast_setpoint_commands,
  input wire voltage_only_mode,
  input wire overtemp_hysteresis_sel,
  input wire [3:0] cable_drop_comp,
  // Measurements
  input wire [7:0] measured_current,
  input wire [11:0] measured_voltage
);

  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_ADDR_ACK = 7'h04;
  localparam [6:0] S_WR_BYTE = 7'h08;
  localparam [6:0] S_WR_ACK = 7'h10;
  localparam [6:0] S_RD_BYTE = 7'h20;
  localparam [6:0] S_RD_ACK = 7'h40;

  // Odd parity: bit is set when the seven data bits hold an even count of ones
  function [7:0] odd_byte;
    input [6:0] data;
    begin
      odd_byte = {~^data, data};
    end
  endfunction

  // Parity-protected word from a high-byte and a low-byte value
  function [15:0] parity_word;
    input [6:0] hi;
    input [6:0] lo;
    begin
      parity_word = {odd_byte(hi), odd_byte(lo)}; // see [R12]
    end
  endfunction

  reg scl_m_r, scl_s_r, scl_d_r;
  reg sda_m_r, sda_s_r, sda_d_r;
  reg [6:0] state_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg rw_r, nack_r, hi_next_r;
  reg [1:0] wr_idx_r;
  reg [7:0] cmd_r;
  reg [7:0] sub_addr_r;
  reg [15:0] tx_word_r;
  reg sda_oe_r, sda_out_r;
  reg [15:0] sel_word;

  wire scl_rise = scl_s_r & ~scl_d_r;
  wire scl_fall = ~scl_s_r & scl_d_r;
  wire bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  wire bus_stop = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  assign sda_out = sda_out_r;
  assign sda_oe = sda_oe_r;

  // Word selected by the stored sub-address; unmapped addresses read zero
  always @* begin
    sel_word = 16'h0000; // see [R14]
    case (sub_addr_r)
      `SUB_VOLTAGE_SETPOINT:
        sel_word = parity_word({2'b00, voltage_setpoint_field[11:7]},
                               voltage_setpoint_field[6:0]); // see [R1]
      `SUB_CURRENT_SETPOINT:
        sel_word = parity_word({6'h00, current_setpoint_field[7]},
                               current_setpoint_field[6:0]); // see [R2]
      `SUB_OVERVOLTAGE_THR:
        sel_word = parity_word({2'b00, overvoltage_threshold_field[11:7]},
                               overvoltage_threshold_field[6:0]); // see [R3]
      `SUB_UNDERVOLTAGE_THR:
        sel_word = parity_word({2'b00, undervoltage_threshold_field[11:7]},
                               undervoltage_threshold_field[6:0]); // see [R4]
      `SUB_CURRENT_POWER:
        sel_word = {current_setpoint_field, power_limit_field}; // see [R5]
      `SUB_FAULT_RESPONSE: begin
        sel_word[`POS_OV_REACTION+1:`POS_OV_REACTION] = overvoltage_reaction; // see [R6]
        sel_word[`POS_UV_REACTION+1:`POS_UV_REACTION] = undervoltage_reaction; // see [R6]
        sel_word[`POS_SHORT_REACTION+1:`POS_SHORT_REACTION] = output_short_reaction;
        sel_word[`POS_SENSE_REACTION+1:`POS_SENSE_REACTION] = sense_pin_short_reaction;
        sel_word[`POS_UV_TIMEOUT+1:`POS_UV_TIMEOUT] = undervoltage_timeout_sel; // see [R7]
        sel_word[`POS_WD_TIMEOUT+1:`POS_WD_TIMEOUT] = watchdog_timeout_sel; // see [R7]
        sel_word[`POS_VO_REACTION+1:`POS_VO_REACTION] = voltage_only_reaction; // see [R7]
        sel_word[`POS_VO_TIMER+1:`POS_VO_TIMER] = voltage_only_timer; // see [R7]
      end
      `SUB_MISC_CONFIG: begin
        sel_word[`POS_BUS_SWITCH] = bus_switch_enable; // see [R8]
        sel_word[`POS_BLEEDER] = bleeder_enable; // see [R8]
        sel_word[`POS_TURN_OFF] = supply_turn_off; // see [R8]
        sel_word[`POS_FAST_CMDS] = fast_setpoint_commands; // see [R8]
        sel_word[`POS_VO_MODE] = voltage_only_mode; // see [R8]
        sel_word[`POS_OT_HYS] = overtemp_hysteresis_sel; // see [R8]
        sel_word[`POS_CABLE_COMP+3:`POS_CABLE_COMP] = cable_drop_comp; // see [R8]
      end
      `SUB_MEASURED_CURRENT:
        sel_word = parity_word({6'h00, measured_current[7]},
                               measured_current[6:0]); // see [R9]
      `SUB_MEASURED_VOLTAGE:
        // Code is passed as measured; step size per range is set upstream, see [R11]
        sel_word = {4'h0, measured_voltage}; // see [R10]
      default:
        sel_word = 16'h0000; // see [R14]
    endcase
  end

  // Pin sampling; only the second and third stages feed edge detection
  always @(posedge mclk) begin
    if (rst) begin
      {scl_m_r, scl_s_r, scl_d_r} <= 3'b111;
      {sda_m_r, sda_s_r, sda_d_r} <= 3'b111;
    end else begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  // Target protocol engine
  always @(posedge mclk) begin
    if (rst) begin
      state_r <= S_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      hi_next_r <= 1'b0;
      wr_idx_r <= 2'b00;
      cmd_r <= `RST_CMD;
      sub_addr_r <= `RST_SUB_ADDR;
      tx_word_r <= 16'h0000;
      sda_oe_r <= 1'b0;
      sda_out_r <= 1'b0;
    end else if (bus_start) begin
      state_r <= S_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (bus_stop) begin
      state_r <= S_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (state_r)
        S_IDLE:
          sda_oe_r <= 1'b0;
        S_ADDR: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_s_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == `BITS_PER_BYTE) begin
            if (shift_r[7:1] == TARGET_ADDR) begin
              rw_r <= shift_r[0];
              sda_oe_r <= 1'b1;
              state_r <= S_ADDR_ACK;
            end else begin
              state_r <= S_IDLE;
            end
          end
        end
        S_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (rw_r) begin
              // Snapshot keeps both bytes of one word coherent
              tx_word_r <= sel_word; // see [R13]
              shift_r <= sel_word[7:0];
              sda_oe_r <= ~sel_word[7];
              hi_next_r <= 1'b1;
              state_r <= S_RD_BYTE;
            end else begin
              sda_oe_r <= 1'b0;
              wr_idx_r <= 2'b00;
              state_r <= S_WR_BYTE;
            end
          end
        end
        S_WR_BYTE: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_s_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == `BITS_PER_BYTE) begin
            sda_oe_r <= 1'b1;
            state_r <= S_WR_ACK;
            if (wr_idx_r == 2'b00) begin
              cmd_r <= shift_r;
            end else if (wr_idx_r == 2'b01 && cmd_r == `CMD_LOC) begin
              sub_addr_r <= shift_r; // see [R13]
            end
            // Other data bytes are acknowledged and dropped, see [R14]
            if (wr_idx_r != 2'b11) begin
              wr_idx_r <= wr_idx_r + 2'b01;
            end
          end
        end
        S_WR_ACK: begin
          if (scl_fall) begin
            sda_oe_r <= 1'b0;
            bit_cnt_r <= 4'h0;
            state_r <= S_WR_BYTE;
          end
        end
        S_RD_BYTE: begin
          if (scl_fall) begin
            if (bit_cnt_r < 4'h7) begin
              shift_r <= {shift_r[6:0], 1'b0};
              sda_oe_r <= ~shift_r[6];
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else begin
              sda_oe_r <= 1'b0;
              state_r <= S_RD_ACK;
            end
          end
        end
        S_RD_ACK: begin
          if (scl_rise) begin
            nack_r <= sda_s_r;
          end else if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (nack_r) begin
              sda_oe_r <= 1'b0;
              state_r <= S_IDLE;
            end else if (hi_next_r) begin
              shift_r <= tx_word_r[15:8];
              sda_oe_r <= ~tx_word_r[15];
              hi_next_r <= 1'b0;
              state_r <= S_RD_BYTE;
            end else begin
              // A longer read restarts with a fresh snapshot, low byte first
              tx_word_r <= sel_word;
              shift_r <= sel_word[7:0];
              sda_oe_r <= ~sel_word[7];
              hi_next_r <= 1'b1;
              state_r <= S_RD_BYTE;
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

endmodule

// [src/telemetry_readback_regs.vh]
// Purpose: Constants for the telemetry read-back register bank
// Assumes: Word-wide telemetry selected by an 8-bit sub-address
// Notes: Positions are bit indices inside the 16-bit word
`ifndef TELEMETRY_READBACK_REGS_VH
`define TELEMETRY_READBACK_REGS_VH

// Command location that takes the sub-address and returns the word
`define CMD_LOC 8'h80

// Sub-addresses of the read-back words
`define SUB_VOLTAGE_SETPOINT 8'h02
`define SUB_CURRENT_SETPOINT 8'h04
`define SUB_OVERVOLTAGE_THR 8'h06
`define SUB_UNDERVOLTAGE_THR 8'h08
`define SUB_CURRENT_POWER 8'h0A
`define SUB_FAULT_RESPONSE 8'h0C
`define SUB_MISC_CONFIG 8'h0E
`define SUB_MEASURED_CURRENT 8'h10
`define SUB_MEASURED_VOLTAGE 8'h12

// Parity bit positions
`define POS_HI_PARITY 15
`define POS_LO_PARITY 7

// Fault-response word field positions (low bit of each field)
`define POS_OV_REACTION 14
`define POS_UV_REACTION 12
`define POS_SHORT_REACTION 10
`define POS_SENSE_REACTION 8
`define POS_UV_TIMEOUT 6
`define POS_WD_TIMEOUT 4
`define POS_VO_REACTION 2
`define POS_VO_TIMER 0

// Configuration word bit positions
`define POS_BUS_SWITCH 14
`define POS_BLEEDER 13
`define POS_TURN_OFF 12
`define POS_FAST_CMDS 11
`define POS_VO_MODE 10
`define POS_OT_HYS 9
`define POS_CABLE_COMP 0

// Reset values
`define RST_SUB_ADDR 8'h00
`define RST_CMD 8'h00

// Bits per serial byte
`define BITS_PER_BYTE 4'h8

`endif

// [sim/telemetry_readback_checker.sv]
// Purpose: Pin-level checks of the telemetry target port
// Assumes: Bus half periods of at least 10 mclk
// Notes: Word contents are judged by the bench
`timescale 1ns/10ps
module telemetry_readback_checker (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Bus pins
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_reset_idle: assert property (disable iff (1'b0) rst |=> !sda_oe)
    else $error("data line driven after reset");
  a_release_quiet: assert property ($fell(rst) |-> !sda_oe [*8])
    else $error("data line driven right after reset release");
  a_drive_low_only: assert property (sda_out == 1'b0)
    else $error("data drive value not low");
  a_hold_scl_high: assert property (scl_in [*5] |-> $stable(sda_oe))
    else $error("data changed while bus clock high");
  a_settle_scl_low: assert property ((!scl_in) [*7] |-> $stable(sda_oe))
    else $error("data changed late in bus clock low");
  a_rise_in_low: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("drive began outside bus clock low");
  a_fall_in_low: assert property ($fell(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("drive ended outside bus clock low");
  a_stop_quiet: assert property (scl_in && $rose(sda_in) |=> !sda_oe [*4])
    else $error("data driven after stop");
  c_ack: cover property ($rose(sda_oe));
  c_start: cover property (scl_in && $fell(sda_in));
  c_stop: cover property (scl_in && $rose(sda_in));
endmodule

bind telemetry_readback_registers telemetry_readback_checker chk_u (.mclk(mclk), .rst(rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

// [sim/bus_host_model.sv]
// Purpose: Two-wire bus controller standing in for the host
// Assumes: Pull-up on the data line
// Notes: Slow bit timing, so the target's pin sampling keeps up
`timescale 1ns/10ps
module bus_host_model (
  // Clock
  input wire mclk,
  // Bus
  input wire sda_wire,
  output reg scl,
  output reg sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task hold;
    repeat (10) @(negedge mclk);
  endtask
  task put_bit(input b);
    sda_pull = !b;
    hold;
    scl = 1'b1;
    hold;
    scl = 1'b0;
  endtask
  task get_bit(output b);
    sda_pull = 1'b0;
    hold;
    scl = 1'b1;
    hold;
    b = sda_wire;
    scl = 1'b0;
  endtask
  task start;
    sda_pull = 1'b0;
    hold;
    scl = 1'b1;
    hold;
    sda_pull = 1'b1;
    hold;
    scl = 1'b0;
  endtask
  task stop;
    sda_pull = 1'b1;
    hold;
    scl = 1'b1;
    hold;
    sda_pull = 1'b0;
    hold;
  endtask
  task send(input [7:0] d, output ack);
    integer i;
    for (i = 7; i >= 0; i = i - 1)
      put_bit(d[i]);
    get_bit(ack);
    ack = !ack;
  endtask
  task recv(input last, output [7:0] d);
    integer i;
    for (i = 7; i >= 0; i = i - 1)
      get_bit(d[i]);
    put_bit(last);
  endtask
  // Sub-address goes to the command location, then the word comes back
  task read_word(input [6:0] ta, input [7:0] sub, output [15:0] w, output ok);
    reg a0, a1, a2, a3;
    start;
    send({ta, 1'h0}, a0);
    send(8'h80, a1);
    send(sub, a2);
    stop;
    start;
    send({ta, 1'h1}, a3);
    recv(1'h0, w[7:0]);
    recv(1'h1, w[15:8]);
    stop;
    ok = a0 & a1 & a2 & a3;
  endtask
endmodule

// [sim/telemetry_readback_registers_tb.sv]
// Purpose: Reads every telemetry word over the bus and checks it
// Assumes: Host model on the far side of the data line
// Notes: Field inputs change between reads, and once inside the long read
`timescale 1ns/10ps
module telemetry_readback_registers_tb;
  localparam [6:0] TA = 7'h18;
  reg mclk;
  reg rst;
  reg [11:0] vs, ov, uv, mv;
  reg [7:0] cs, pl, mc;
  reg [15:0] fr;
  reg [5:0] fl;
  reg [3:0] cdc;
  reg ak;
  integer bad_count, samples_checked;
  wire scl, sda_pull, sda_out, sda_oe;
  // Open-drain line: pull-up level unless either side pulls it low
  wire sda_in = !sda_pull && (sda_oe ? sda_out : 1'b1);

  telemetry_readback_registers #(.TARGET_ADDR(TA)) dut_u (.mclk(mclk), .rst(rst),
    .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .voltage_setpoint_field(vs), .current_setpoint_field(cs),
    .overvoltage_threshold_field(ov), .undervoltage_threshold_field(uv),
    .power_limit_field(pl), .overvoltage_reaction(fr[15:14]),
    .undervoltage_reaction(fr[13:12]), .output_short_reaction(fr[11:10]),
    .sense_pin_short_reaction(fr[9:8]), .undervoltage_timeout_sel(fr[7:6]),
    .watchdog_timeout_sel(fr[5:4]), .voltage_only_reaction(fr[3:2]),
    .voltage_only_timer(fr[1:0]), .bus_switch_enable(fl[5]), .bleeder_enable(fl[4]),
    .supply_turn_off(fl[3]), .fast_setpoint_commands(fl[2]), .voltage_only_mode(fl[1]),
    .overtemp_hysteresis_sel(fl[0]), .cable_drop_comp(cdc),
    .measured_current(mc), .measured_voltage(mv));
  bus_host_model host_u (.mclk(mclk), .sda_wire(sda_in), .scl(scl), .sda_pull(sda_pull));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Parity bits are recomputed here so a shared slip cannot hide
  function [15:0] pv(input [11:0] v);
    pv = {~^v[11:7], 2'h0, v[11:7], ~^v[6:0], v[6:0]};
  endfunction
  function [15:0] pc(input [7:0] c);
    pc = {~c[7], 6'h00, c[7], ~^c[6:0], c[6:0]};
  endfunction
  function [15:0] expect_word(input [7:0] s);
    case (s)
      8'h02: expect_word = pv(vs);
      8'h04: expect_word = pc(cs);
      8'h06: expect_word = pv(ov);
      8'h08: expect_word = pv(uv);
      8'h0A: expect_word = {cs, pl};
      8'h0C: expect_word = fr;
      8'h0E: expect_word = {1'h0, fl, 5'h00, cdc};
      8'h10: expect_word = pc(mc);
      8'h12: expect_word = {4'h0, mv};
      default: expect_word = 16'h0000;
    endcase
  endfunction

  task chk(input [15:0] got, input [15:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task read_check(input [7:0] s);
    reg [15:0] w;
    reg ok;
    host_u.read_word(TA, s, w, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(w, expect_word(s));
  endtask
  task set_fields(input [11:0] p);
    @(negedge mclk);
    {vs, ov, uv, mv} = {p, ~p, p[5:0], p[11:6], p ^ 12'h5A5};
    {cs, pl, mc} = {p[7:0], ~p[11:4], p[11:4]};
    {fr, fl, cdc} = {p, p[11:8], p[5:0], p[9:6]};
  endtask

  task t_all_words(input [11:0] p);
    integer s;
    set_fields(p);
    for (s = 2; s <= 18; s = s + 2)
      read_check(s[7:0]);
  endtask
  task t_voltage_edges;
    mv = 12'hFFF;
    read_check(8'h12);
    mv = 12'h000;
    read_check(8'h12);
  endtask
  task t_ro_write;
    host_u.start;
    host_u.send({TA, 1'h0}, ak);
    host_u.send(8'h02, ak);
    host_u.send(8'hFF, ak);
    host_u.stop;
    chk({15'h0000, ak}, 16'h0001);
    read_check(8'h02);
    read_check(8'h14);
  endtask
  task t_wrong_target;
    host_u.start;
    host_u.send({~TA, 1'h0}, ak);
    host_u.stop;
    chk({15'h0000, ak}, 16'h0000);
  endtask
  // A reset in mid-frame must drop the drive and leave the port usable
  task t_mid_reset;
    host_u.start;
    host_u.send({TA, 1'h0}, ak);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    chk({15'h0000, sda_oe}, 16'h0000);
    rst = 1'b0;
    host_u.stop;
    read_check(8'h0C);
  endtask
  // Extra write bytes are dropped; a third read byte takes a fresh snapshot
  task t_long_read;
    reg [7:0] b0, b1, b2, b3, m0;
    reg a0, a1, a2, a3;
    m0 = mc;
    host_u.start;
    host_u.send({TA, 1'h0}, a0);
    host_u.send(8'h80, a1);
    host_u.send(8'h10, a2);
    host_u.send(8'h04, a3);
    host_u.stop;
    chk({12'h000, a0, a1, a2, a3}, 16'h000F);
    host_u.start;
    host_u.send({TA, 1'h1}, a0);
    host_u.recv(1'h0, b0);
    mc = mc ^ 8'hFF;
    host_u.recv(1'h0, b1);
    host_u.recv(1'h0, b2);
    host_u.recv(1'h1, b3);
    host_u.stop;
    chk({15'h0000, a0}, 16'h0001);
    chk({b1, b0}, pc(m0));
    chk({b3, b2}, pc(mc));
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    // About twice the expected length of all scenarios
    #600000;
    bad_count = bad_count + 1;
    summarize;
  end

  initial begin
    rst = 1'b1;
    bad_count = 0;
    samples_checked = 0;
    {vs, ov, uv, mv, cs, pl, mc, fr, fl, cdc} = 0;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    repeat (5) @(negedge mclk);
    chk({15'h0000, sda_oe}, 16'h0000);
    t_all_words(12'h9C6);
    t_all_words(12'h639);
    t_voltage_edges;
    t_ro_write;
    t_wrong_target;
    t_mid_reset;
    t_long_read;
    summarize;
  end
endmodule
